//--- rtl/fsq_pkg.sv
package fsq_pkg;
  // timing in printed units, cycle counts derived at the 50 MHz clock
  localparam int CLK_MHZ = 50;
  localparam int POWER_UP_TIME_US = 300;
  localparam int POWER_UP_CYC = POWER_UP_TIME_US * CLK_MHZ;
  localparam int RESET_PULSE_WIDTH_NS = 200;
  localparam int RESET_PULSE_CYC = (RESET_PULSE_WIDTH_NS * CLK_MHZ + 999) / 1000;
  localparam int RESET_RECOVERY_TIME_US = 35;
  localparam int RESET_RECOVERY_CYC = RESET_RECOVERY_TIME_US * CLK_MHZ;
  localparam int RESET_SETUP_TIME_NS = 50;
  localparam int RESET_SETUP_CYC = (RESET_SETUP_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam int RESET_HOLD_TIME_NS = 50;
  localparam int RESET_HOLD_CYC = (RESET_HOLD_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam int CS_HIGH_TIME_NS = 20;
  localparam int CS_HIGH_CYC = (CS_HIGH_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam int OUTPUT_DISABLE_TIME_NS = 20;
  localparam int OUTPUT_DISABLE_RAW = OUTPUT_DISABLE_TIME_NS * CLK_MHZ / 1000;
  localparam int OUTPUT_DISABLE_CYC = (OUTPUT_DISABLE_RAW < 1) ? 1 : OUTPUT_DISABLE_RAW;
  localparam int AUTO_BOOT_PULSE_MAX_US = 5;
  localparam int AUTO_BOOT_PULSE_CYC = AUTO_BOOT_PULSE_MAX_US * CLK_MHZ;
  localparam int CNT_W = 16;
  // host controller register map (byte offsets)
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_PULSE = 4'h8;
  localparam int CTRL_USE_IO3 = 0;
  localparam int CTRL_AUTO_BOOT = 1;
  localparam int CTRL_CS_REQ = 2;
  localparam int CTRL_START = 3;
  localparam int STAT_BUSY = 0;
  localparam int STAT_POWERED = 1;
  localparam int STAT_CS_N = 2;
  localparam int STAT_PENDING = 3;
  localparam logic [2:0] CTRL_RESET = 3'h0;
  localparam logic [CNT_W-1:0] PULSE_RESET = CNT_W'(RESET_PULSE_CYC);
  typedef enum logic [3:0] {
    DS_POR = 4'b0001,
    DS_STBY = 4'b0010,
    DS_HWRST = 4'b0100,
    DS_HOLD = 4'b1000
  } fsq_dev_state_t;
  typedef enum logic [4:0] {
    HS_PWR = 5'b00001,
    HS_IDLE = 5'b00010,
    HS_LOW = 5'b00100,
    HS_HIDRV = 5'b01000,
    HS_HOLD = 5'b10000
  } fsq_host_state_t;
endpackage : fsq_pkg

//--- rtl/fsq_link_if.sv
`timescale 1ns/10ps
interface fsq_link_if;
  logic cs_n;
  logic rst_host_o;
  logic rst_host_oe;
  logic io3_host_o;
  logic io3_host_oe;
  logic io3_dev_o;
  logic io3_dev_oe;
  wire rst_n;
  wire io3;
  // pull-up: an undriven pin reads high RULE_19
  assign rst_n = rst_host_oe ? rst_host_o : 1'b1;
  assign io3 = io3_dev_oe ? io3_dev_o : (io3_host_oe ? io3_host_o : 1'b1);
  modport dev (
    input cs_n,
    input rst_n,
    input io3,
    output io3_dev_o,
    output io3_dev_oe
  );
  modport host (
    output cs_n,
    output rst_host_o,
    output rst_host_oe,
    output io3_host_o,
    output io3_host_oe
  );
endinterface : fsq_link_if

//--- rtl/fsq_low_qual.sv
`timescale 1ns/10ps
module fsq_low_qual #(
  parameter int unsigned LOW_CYC = 10
) (
  // clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // pin and gating
  input wire logic pin_in,
  input wire logic enable,
  // results
  output logic level_s,
  output logic hit
);
  logic meta_reg;
  logic [15:0] cnt_reg;
  logic counting;
  logic reached;

  initial begin
    if (LOW_CYC < 1 || LOW_CYC > 65535) begin
      $error("fsq_low_qual: LOW_CYC out of range");
    end
  end

  assign counting = enable && !level_s;
  assign reached = counting && (cnt_reg == 16'(LOW_CYC - 1));

  // a low shorter than LOW_CYC clears the count and never fires RULE_21
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      meta_reg <= 1'b1;
      level_s <= 1'b1;
      cnt_reg <= 16'h0000;
      hit <= 1'b0;
    end else begin
      meta_reg <= pin_in;
      level_s <= meta_reg;
      cnt_reg <= !counting ? 16'h0000 : (reached ? cnt_reg : cnt_reg + 16'h0001);
      hit <= reached && (cnt_reg != 16'(LOW_CYC));
    end
  end
endmodule : fsq_low_qual

//--- rtl/fsq_dev.sv
// The placing of the registers and the Avalon-MM slave port were left to the implementer.
`timescale 1ns/10ps
// What this block and fsq_host do
// RULE_01: power-on sequence runs for power_up_time
// RULE_02: host keeps chip select high during power-up
// RULE_03: shared pin resets when enabled and idle
// RULE_04: reset input ignored during power-on sequence
// RULE_05: reset low past power-up delays chip select
// RULE_06: reset high reset_setup_time before next reset
// RULE_07: qualified reset aborts, tristates, ignores commands
// RULE_08: warm reset restores registers within recovery time
// RULE_09: chip select low only after recovery time
// RULE_10: failed power-on makes reset rerun power-on
// RULE_11: host raises chip select during reset recovery
// RULE_12: auto boot limits reset pulse to 5us
// RULE_13: pulse plus hold covers recovery time
// RULE_14: quad mode ignores shared pin after select
// RULE_15: device drives data line 3 high, releases
// RULE_16: host drives data line 3 high, releases
// RULE_17: selected chip uses shared pin as data
// RULE_18: software reset works whatever the pin level
// RULE_19: reset inputs pulled up when unconnected
// RULE_20: power-up ends in standby, write latch cleared
// RULE_21: short reset pulses are filtered out
module fsq_dev #(
  parameter int POWER_UP_CYC = fsq_pkg::POWER_UP_CYC
) (
  // clock and reset; reset release stands for supply reaching its minimum
  input wire logic clock,
  input wire logic sys_rst,
  // link to the host
  fsq_link_if.dev link,
  // configuration bits from the register core
  input wire logic status_reg_2_reset_en,
  input wire logic volatile_config_reg_1_quad,
  input wire logic por_fault,
  // command core
  input wire logic sw_reset_cmd,
  input wire logic quad_out_en,
  input wire logic quad_out_bit,
  input wire logic quad_read_end,
  // status to the core
  output logic standby,
  output logic por_busy,
  output logic hw_reset_busy,
  output logic outputs_hiz,
  output logic abort_op,
  output logic regs_restore,
  output logic write_enable_latch_clr,
  output logic data_line_3_in
);
  localparam int CW = fsq_pkg::CNT_W;
  localparam logic [CW-1:0] PU_LAST = CW'(POWER_UP_CYC - 1);
  localparam logic [CW-1:0] RPH_LAST = CW'(fsq_pkg::RESET_RECOVERY_CYC - 1);
  localparam logic [7:0] CS_CYC = 8'(fsq_pkg::CS_HIGH_CYC);
  localparam logic [7:0] DIS_CYC = 8'(fsq_pkg::OUTPUT_DISABLE_CYC);

  fsq_pkg::fsq_dev_state_t state_reg;
  fsq_pkg::fsq_dev_state_t state_next;
  logic [CW-1:0] timer_reg;
  logic [CW-1:0] timer_next;
  logic por_ok_reg;
  logic por_ok_next;
  logic cs_meta_reg;
  logic cs_s_reg;
  logic [7:0] cs_hi_reg;
  logic [7:0] dis_reg;
  logic [7:0] dis_next;
  logic io3_o_next;
  logic io3_oe_next;
  logic ded_lvl;
  logic ded_hit;
  logic io3_lvl;
  logic io3_hit;
  logic io3_fn;
  logic in_por;
  logic rst_hit;
  logic rst_low;
  logic sw_go;
  logic go_reset;
  logic enter_stby;
  logic timer_done;

  initial begin
    if (POWER_UP_CYC < 1 || POWER_UP_CYC > 65535) begin
      $error("fsq_dev: POWER_UP_CYC out of range");
    end
  end

  assign in_por = (state_reg == fsq_pkg::DS_POR);
  // reset function needs enable, plus idle chip select or single mode RULE_03
  // quad mode waits cs_high_time after select ends RULE_14
  // a selected chip in quad mode treats the pin as data RULE_17
  assign io3_fn = status_reg_2_reset_en &&
                  (!volatile_config_reg_1_quad || (cs_s_reg && cs_hi_reg >= CS_CYC));

  // qualifiers are disabled while power-on runs RULE_04
  fsq_low_qual #(
    .LOW_CYC(fsq_pkg::RESET_PULSE_CYC)
  ) u_ded_qual (
    .clock(clock),
    .sys_rst(sys_rst),
    .pin_in(link.rst_n),
    .enable(!in_por),
    .level_s(ded_lvl),
    .hit(ded_hit)
  );

  fsq_low_qual #(
    .LOW_CYC(fsq_pkg::RESET_PULSE_CYC)
  ) u_io3_qual (
    .clock(clock),
    .sys_rst(sys_rst),
    .pin_in(link.io3),
    .enable(!in_por && io3_fn),
    .level_s(io3_lvl),
    .hit(io3_hit)
  );

  assign rst_hit = ded_hit || io3_hit;
  assign rst_low = !ded_lvl || (io3_fn && !io3_lvl);
  // the command is honoured at any pin level RULE_18
  assign sw_go = sw_reset_cmd && (state_reg == fsq_pkg::DS_STBY);
  assign go_reset = (state_reg == fsq_pkg::DS_STBY) && (rst_hit || sw_go);
  assign timer_done = in_por ? (timer_reg == PU_LAST) : (timer_reg == RPH_LAST);
  assign enter_stby = (state_next == fsq_pkg::DS_STBY) && (state_reg != fsq_pkg::DS_STBY);

  always_comb begin
    state_next = state_reg;
    timer_next = timer_reg + CW'(1);
    por_ok_next = por_ok_reg;
    case (state_reg)
      fsq_pkg::DS_POR: begin
        if (timer_done) begin // RULE_01
          por_ok_next = !por_fault;
          timer_next = timer_reg;
          // a reset held through the end of power-up keeps the device in reset
          state_next = rst_low ? fsq_pkg::DS_HOLD : fsq_pkg::DS_STBY;
        end
      end
      fsq_pkg::DS_STBY: begin
        timer_next = '0;
        if (go_reset) begin
          // a bad power-on turns the next reset into a full power-on RULE_10
          state_next = por_ok_reg ? fsq_pkg::DS_HWRST : fsq_pkg::DS_POR;
        end
      end
      fsq_pkg::DS_HWRST: begin
        if (timer_done) begin // RULE_08
          timer_next = timer_reg;
          state_next = rst_low ? fsq_pkg::DS_HOLD : fsq_pkg::DS_STBY;
        end
      end
      fsq_pkg::DS_HOLD: begin
        timer_next = '0;
        if (!rst_low) begin
          state_next = fsq_pkg::DS_STBY;
        end
      end
      default: begin
        state_next = fsq_pkg::DS_POR;
        timer_next = '0;
      end
    endcase
  end

  // data line 3 driver: after a quad read drive high, then let go RULE_15
  always_comb begin
    dis_next = (dis_reg != 8'h00) ? dis_reg - 8'h01 : 8'h00;
    io3_o_next = 1'b1;
    io3_oe_next = 1'b0;
    if (state_next != fsq_pkg::DS_STBY) begin
      dis_next = 8'h00;
    end else if (quad_read_end) begin
      dis_next = DIS_CYC - 8'h01;
      io3_oe_next = 1'b1;
    end else if (dis_reg != 8'h00) begin
      io3_oe_next = 1'b1;
    end else if (quad_out_en && !cs_s_reg) begin
      io3_o_next = quad_out_bit;
      io3_oe_next = 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      state_reg <= fsq_pkg::DS_POR;
      timer_reg <= '0;
      por_ok_reg <= 1'b0;
      dis_reg <= 8'h00;
    end else begin
      state_reg <= state_next;
      timer_reg <= timer_next;
      por_ok_reg <= por_ok_next;
      dis_reg <= dis_next;
    end
  end

  // chip select synchroniser and high-time counter, saturating
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      cs_meta_reg <= 1'b1;
      cs_s_reg <= 1'b1;
      cs_hi_reg <= 8'h00;
    end else begin
      cs_meta_reg <= link.cs_n;
      cs_s_reg <= cs_meta_reg;
      cs_hi_reg <= !cs_s_reg ? 8'h00 : ((cs_hi_reg == 8'hff) ? cs_hi_reg : cs_hi_reg + 8'h01);
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      standby <= 1'b0;
      por_busy <= 1'b1;
      hw_reset_busy <= 1'b0;
      outputs_hiz <= 1'b1;
      abort_op <= 1'b0;
      regs_restore <= 1'b0;
      write_enable_latch_clr <= 1'b0;
      link.io3_dev_o <= 1'b1;
      link.io3_dev_oe <= 1'b0;
      data_line_3_in <= 1'b1;
    end else begin
      standby <= (state_next == fsq_pkg::DS_STBY);
      por_busy <= (state_next == fsq_pkg::DS_POR);
      hw_reset_busy <= (state_next == fsq_pkg::DS_HWRST) || (state_next == fsq_pkg::DS_HOLD);
      // outside standby every output floats and commands are ignored RULE_07
      outputs_hiz <= (state_next != fsq_pkg::DS_STBY);
      abort_op <= go_reset; // RULE_07
      regs_restore <= enter_stby; // RULE_08
      write_enable_latch_clr <= enter_stby; // RULE_20
      link.io3_dev_o <= io3_o_next;
      link.io3_dev_oe <= io3_oe_next;
      data_line_3_in <= io3_lvl;
    end
  end
endmodule : fsq_dev

//--- rtl/fsq_host.sv
`timescale 1ns/10ps
module fsq_host #(
  parameter int POWER_UP_CYC = fsq_pkg::POWER_UP_CYC
) (
  // clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // avalon-mm slave
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // link to the flash
  fsq_link_if.host link
);
  localparam int CW = fsq_pkg::CNT_W;
  localparam logic [CW-1:0] PU_LAST = CW'(POWER_UP_CYC - 1);
  localparam logic [CW-1:0] RP_MIN = CW'(fsq_pkg::RESET_PULSE_CYC);
  localparam logic [CW-1:0] AB_MAX = CW'(fsq_pkg::AUTO_BOOT_PULSE_CYC);
  localparam logic [CW-1:0] RPH_LAST = CW'(fsq_pkg::RESET_RECOVERY_CYC - 1);
  localparam logic [7:0] RS_CYC = 8'(fsq_pkg::RESET_SETUP_CYC);
  localparam logic [7:0] RH_LAST = 8'(fsq_pkg::RESET_HOLD_CYC - 1);

  fsq_pkg::fsq_host_state_t state_reg;
  fsq_pkg::fsq_host_state_t state_next;
  logic [2:0] ctrl_reg;
  logic [CW-1:0] pulse_reg;
  logic pending_reg;
  logic [CW-1:0] cnt_reg;
  logic [CW-1:0] cnt_next;
  logic [7:0] hold_reg;
  logic [7:0] rs_reg;
  logic [CW-1:0] width_lo;
  logic [CW-1:0] width;
  logic acc;
  logic wr_go;
  logic wr_ctrl;
  logic wr_pulse;
  logic start_set;
  logic take;
  logic use_io3;
  logic [31:0] rd_mux;
  logic drive_low;
  logic drive_high;

  initial begin
    if (POWER_UP_CYC < 1 || POWER_UP_CYC > 65535) begin
      $error("fsq_host: POWER_UP_CYC out of range");
    end
  end

  assign acc = avs_read || avs_write;
  assign wr_go = avs_write && !avs_waitrequest;
  assign wr_ctrl = wr_go && (avs_address == fsq_pkg::REG_CTRL);
  assign wr_pulse = wr_go && (avs_address == fsq_pkg::REG_PULSE);
  assign start_set = wr_ctrl && avs_writedata[fsq_pkg::CTRL_START];
  assign use_io3 = ctrl_reg[fsq_pkg::CTRL_USE_IO3];
  // setup time high before a new low RULE_06
  assign take = pending_reg && (state_reg == fsq_pkg::HS_IDLE) && (rs_reg >= RS_CYC);
  // width never below the filter minimum, capped under auto boot RULE_12
  assign width_lo = (pulse_reg < RP_MIN) ? RP_MIN : pulse_reg;
  assign width = (ctrl_reg[fsq_pkg::CTRL_AUTO_BOOT] && width_lo > AB_MAX) ? AB_MAX : width_lo;
  assign drive_low = (state_next == fsq_pkg::HS_LOW);
  // drive high before releasing the shared line RULE_16
  assign drive_high = (state_next == fsq_pkg::HS_HIDRV);
  assign rd_mux = (avs_address == fsq_pkg::REG_CTRL) ? {29'h0, ctrl_reg} :
                  (avs_address == fsq_pkg::REG_PULSE) ? {16'h0, pulse_reg} :
                  (avs_address == fsq_pkg::REG_STATUS) ?
                  {28'h0, pending_reg, link.cs_n, (state_reg != fsq_pkg::HS_PWR),
                   (state_reg != fsq_pkg::HS_IDLE)} : 32'h0;

  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg + CW'(1);
    case (state_reg)
      fsq_pkg::HS_PWR: begin
        if (cnt_reg == PU_LAST) begin // RULE_02
          state_next = fsq_pkg::HS_IDLE;
        end
      end
      fsq_pkg::HS_IDLE: begin
        cnt_next = '0;
        if (take) begin
          state_next = fsq_pkg::HS_LOW;
        end
      end
      fsq_pkg::HS_LOW: begin
        if (cnt_reg == width - CW'(1)) begin
          state_next = use_io3 ? fsq_pkg::HS_HIDRV : fsq_pkg::HS_HOLD;
        end
      end
      fsq_pkg::HS_HIDRV: begin
        state_next = fsq_pkg::HS_HOLD;
      end
      fsq_pkg::HS_HOLD: begin
        // hold time met and pulse plus hold covers recovery RULE_05 RULE_09 RULE_13
        if (hold_reg >= RH_LAST && cnt_reg >= RPH_LAST) begin
          state_next = fsq_pkg::HS_IDLE;
        end
        if (cnt_reg == {CW{1'b1}}) begin
          cnt_next = cnt_reg;
        end
      end
      default: begin
        state_next = fsq_pkg::HS_PWR;
        cnt_next = '0;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      state_reg <= fsq_pkg::HS_PWR;
      cnt_reg <= '0;
      hold_reg <= 8'h00;
      rs_reg <= 8'h00;
      pending_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      hold_reg <= (state_reg == fsq_pkg::HS_HOLD) ? ((hold_reg == 8'hff) ? hold_reg :
                  hold_reg + 8'h01) : 8'h00;
      rs_reg <= (state_reg == fsq_pkg::HS_IDLE) ? ((rs_reg == 8'hff) ? rs_reg :
                rs_reg + 8'h01) : 8'h00;
      // a start written in the cycle of the take is kept
      pending_reg <= start_set || (pending_reg && !take);
    end
  end

  // bus slave: one wait cycle, then the answer
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0;
      ctrl_reg <= fsq_pkg::CTRL_RESET;
      pulse_reg <= fsq_pkg::PULSE_RESET;
    end else begin
      avs_waitrequest <= !(acc && avs_waitrequest);
      if (avs_read && avs_waitrequest) begin
        avs_readdata <= rd_mux;
      end
      if (wr_ctrl) begin
        ctrl_reg <= avs_writedata[2:0];
      end
      if (wr_pulse) begin
        pulse_reg <= avs_writedata[CW-1:0];
      end
    end
  end

  // pins; chip select is forced high through power-up and every reset RULE_02 RULE_11
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      link.cs_n <= 1'b1;
      link.rst_host_o <= 1'b1;
      link.rst_host_oe <= 1'b0;
      link.io3_host_o <= 1'b1;
      link.io3_host_oe <= 1'b0;
    end else begin
      link.cs_n <= !((state_next == fsq_pkg::HS_IDLE) && ctrl_reg[fsq_pkg::CTRL_CS_REQ] &&
                     !pending_reg && !start_set);
      link.rst_host_o <= !drive_low;
      link.rst_host_oe <= !use_io3 && drive_low;
      link.io3_host_o <= !drive_low;
      link.io3_host_oe <= use_io3 && (drive_low || drive_high);
    end
  end
endmodule : fsq_host

//--- sim/fsq_link_chk.sv
`timescale 1ns/10ps
module fsq_link_chk #(
  parameter int POWER_UP_CYC = fsq_pkg::POWER_UP_CYC
) (
  // clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // link signals
  input wire logic cs_n,
  input wire logic rst_n,
  input wire logic io3,
  input wire logic io3_host_o,
  input wire logic io3_host_oe,
  input wire logic io3_dev_o,
  input wire logic io3_dev_oe
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (sys_rst);
  // a low data line only means reset while deselected
  wire pin_lo = !rst_n || (cs_n && !io3);
  logic [15:0] up_reg;
  logic [15:0] lo_reg;
  logic [15:0] hi_reg;
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      up_reg <= 16'h0000;
      lo_reg <= 16'hffff;
      hi_reg <= 16'h0000;
    end else begin
      if (up_reg != 16'hffff) up_reg <= up_reg + 16'h0001;
      if ($rose(pin_lo)) lo_reg <= 16'h0000;
      else if (lo_reg != 16'hffff) lo_reg <= lo_reg + 16'h0001;
      if (pin_lo) hi_reg <= 16'h0000;
      else if (hi_reg != 16'hffff) hi_reg <= hi_reg + 16'h0001;
    end
  end
  property p_pwr_cs;
    (int'(up_reg) < POWER_UP_CYC) |-> cs_n;
  endproperty
  a_pwr_cs: assert property (p_pwr_cs) else $error("select in power-up");
  property p_pwr_pin;
    (int'(up_reg) < POWER_UP_CYC) |-> !pin_lo;
  endproperty
  a_pwr_pin: assert property (p_pwr_pin) else $error("reset in power-up");
  // two cycles of slack for the edge at which the count starts
  property p_rec;
    $fell(cs_n) |-> int'(lo_reg) >= fsq_pkg::RESET_RECOVERY_CYC - 2;
  endproperty
  a_rec: assert property (p_rec) else $error("select in recovery");
  property p_hold;
    $fell(cs_n) |-> int'(hi_reg) >= fsq_pkg::RESET_HOLD_CYC;
  endproperty
  a_hold: assert property (p_hold) else $error("select before hold");
  property p_setup;
    $rose(pin_lo) |-> int'(hi_reg) >= fsq_pkg::RESET_SETUP_CYC;
  endproperty
  a_setup: assert property (p_setup) else $error("reset setup short");
  property p_cs_rst;
    pin_lo |-> cs_n;
  endproperty
  a_cs_rst: assert property (p_cs_rst) else $error("select during reset");
  property p_host_rel;
    $fell(io3_host_oe) |-> $past(io3_host_o);
  endproperty
  a_host_rel: assert property (p_host_rel) else $error("host released low");
  property p_dev_rel;
    $fell(io3_dev_oe) |-> $past(io3_dev_o) && $past(io3_dev_oe, 2) && io3;
  endproperty
  a_dev_rel: assert property (p_dev_rel) else $error("device released low");
  c_hw: cover property ($rose(pin_lo));
  c_cs: cover property ($fell(cs_n));
  c_rel: cover property ($fell(io3_dev_oe));
endmodule : fsq_link_chk

//--- sim/test_flash_reset_sequencer.sv
`timescale 1ns/10ps
module test_flash_reset_sequencer;
  localparam int PU = 200;
  localparam int REC = fsq_pkg::RESET_RECOVERY_CYC;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic [3:0] adr = 4'h0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wd = 32'h0;
  logic [31:0] rdata;
  logic wreq;
  logic s2_en = 1'b1;
  logic quad = 1'b0;
  logic por_fault = 1'b0;
  logic sw_rst = 1'b0;
  logic q_en = 1'b0;
  logic q_bit = 1'b1;
  logic q_end = 1'b0;
  logic stby, por_busy, hw_busy, hiz, abort, restore, wel_clr, d3_in;
  logic stby_b, por_b, hw_b;
  logic [31:0] q;
  int num_errors = 0;
  int check_count = 0;
  int n;
  fsq_link_if link ();
  fsq_link_if link_b ();
  wire [7:0] w = {hw_b, por_b, link.cs_n, link.rst_n, link.io3, hw_busy, stby_b, stby};
  always #10 clock = ~clock;
  fsq_host #(.POWER_UP_CYC(PU)) u_fsq_host (.clock, .sys_rst, .avs_address(adr),
    .avs_read(rd), .avs_write(wr), .avs_writedata(wd), .avs_readdata(rdata),
    .avs_waitrequest(wreq), .link(link));
  fsq_dev #(.POWER_UP_CYC(PU)) u_fsq_dev (.clock, .sys_rst, .link(link),
    .status_reg_2_reset_en(s2_en), .volatile_config_reg_1_quad(quad), .por_fault,
    .sw_reset_cmd(sw_rst), .quad_out_en(q_en), .quad_out_bit(q_bit), .quad_read_end(q_end),
    .standby(stby), .por_busy, .hw_reset_busy(hw_busy), .outputs_hiz(hiz), .abort_op(abort),
    .regs_restore(restore), .write_enable_latch_clr(wel_clr), .data_line_3_in(d3_in));
  // second device faces the bench, so pulses can be shorter than the host allows
  fsq_dev #(.POWER_UP_CYC(PU)) u_fsq_dev_b (.clock, .sys_rst, .link(link_b),
    .status_reg_2_reset_en(s2_en), .volatile_config_reg_1_quad(quad), .por_fault,
    .sw_reset_cmd(1'b0), .quad_out_en(1'b0), .quad_out_bit(1'b0), .quad_read_end(1'b0),
    .standby(stby_b), .por_busy(por_b), .hw_reset_busy(hw_b), .outputs_hiz(), .abort_op(),
    .regs_restore(), .write_enable_latch_clr(), .data_line_3_in());
  fsq_link_chk #(.POWER_UP_CYC(PU)) u_fsq_link_chk (.clock, .sys_rst, .cs_n(link.cs_n),
    .rst_n(link.rst_n), .io3(link.io3), .io3_host_o(link.io3_host_o),
    .io3_host_oe(link.io3_host_oe), .io3_dev_o(link.io3_dev_o), .io3_dev_oe(link.io3_dev_oe));
  task automatic conclude;
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : conclude
  task automatic ck(input string s, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", s, e, g);
    end
  endtask : ck
  task automatic hang(input string s);
    num_errors++;
    $display("ERROR %s expected answer seen timeout", s);
    conclude();
  endtask : hang
  task automatic bus(input logic w_en, input logic [3:0] a, input logic [31:0] d);
    int k;
    @(posedge clock);
    adr <= a;
    wd <= d;
    wr <= w_en;
    rd <= !w_en;
    k = 0;
    do begin
      @(negedge clock);
      k++;
    end while (wreq !== 1'b0 && k < 40);
    if (wreq !== 1'b0) hang("waitrequest");
    @(posedge clock);
    q = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask : bus
  // counts falling edges until the watched signal takes the value
  task automatic wt(input int i, input logic v, input int lim);
    n = 0;
    do begin
      @(negedge clock);
      n++;
    end while (w[i] !== v && n <= lim);
    if (w[i] !== v) hang("wait");
  endtask : wt
  task automatic pulse_b(input int k);
    repeat (4) @(posedge clock);
    link_b.rst_host_oe <= 1'b1;
    repeat (k) @(posedge clock);
    link_b.rst_host_oe <= 1'b0;
  endtask : pulse_b
  initial begin
    link_b.cs_n = 1'b1;
    link_b.rst_host_o = 1'b0;
    link_b.rst_host_oe = 1'b1;
    link_b.io3_host_o = 1'b1;
    link_b.io3_host_oe = 1'b0;
    repeat (5) @(posedge clock);
    sys_rst <= 1'b0;
    @(negedge clock);
    ck("por_busy", 32'h1, por_busy);
    bus(1'b0, fsq_pkg::REG_PULSE, 32'h0);
    ck("pulse_reg", 32'h0000_000a, q);
    bus(1'b0, 4'hc, 32'h0);
    ck("unmapped", 32'h0, q);
    bus(1'b0, fsq_pkg::REG_STATUS, 32'h0);
    ck("powered", 32'h0, q[fsq_pkg::STAT_POWERED]);
    repeat (PU - 30) @(negedge clock);
    ck("early_standby", 32'h0, stby);
    wt(0, 1'b1, 60);
    // the pulses stand for one cycle from the edge that raises standby or busy
    ck("wel_clr", 32'h1, wel_clr);
    ck("held_b", 32'h1, hw_b);
    @(posedge clock);
    link_b.rst_host_oe <= 1'b0;
    wt(1, 1'b1, 30);
    pulse_b(fsq_pkg::RESET_PULSE_CYC - 1);
    repeat (30) @(negedge clock);
    ck("short_pulse", 32'h0, hw_b);
    pulse_b(fsq_pkg::RESET_PULSE_CYC);
    wt(7, 1'b1, 30);
    wt(1, 1'b1, REC + 100);
    ck("warm_len_b", 32'h1, 32'(n >= REC - 8 && n <= REC + 8));
    bus(1'b1, fsq_pkg::REG_CTRL, 32'h0000_0008);
    wt(4, 1'b0, 20);
    wt(4, 1'b1, 20);
    ck("rst_width", 32'h0000_000a, 32'(n));
    wt(2, 1'b1, 10);
    ck("abort", 32'h1, abort);
    ck("hiz", 32'h1, hiz);
    wt(0, 1'b1, REC + 100);
    ck("warm_len", 32'h1, 32'(n >= REC - 8 && n <= REC + 8));
    ck("restore", 32'h1, restore);
    @(posedge clock);
    sw_rst <= 1'b1;
    @(posedge clock);
    sw_rst <= 1'b0;
    wt(2, 1'b1, 10);
    wt(0, 1'b1, REC + 100);
    @(posedge clock);
    quad <= 1'b1;
    bus(1'b1, fsq_pkg::REG_CTRL, 32'h0000_0004);
    wt(5, 1'b0, 20);
    @(posedge clock);
    q_en <= 1'b1;
    q_bit <= 1'b0;
    repeat (30) @(negedge clock);
    ck("d3_data", 32'h0, d3_in);
    ck("no_reset", 32'h0, hw_busy);
    @(posedge clock);
    q_bit <= 1'b1;
    @(posedge clock);
    q_en <= 1'b0;
    q_end <= 1'b1;
    @(posedge clock);
    q_end <= 1'b0;
    bus(1'b1, fsq_pkg::REG_PULSE, 32'h0000_0190);
    bus(1'b1, fsq_pkg::REG_CTRL, 32'h0000_000f);
    wt(3, 1'b0, 40);
    wt(3, 1'b1, 500);
    ck("boot_width", 32'(fsq_pkg::AUTO_BOOT_PULSE_CYC), 32'(n));
    ck("io3_reset", 32'h1, hw_busy);
    wt(0, 1'b1, REC + 100);
    wt(5, 1'b0, 100);
    @(posedge clock);
    s2_en <= 1'b0;
    bus(1'b1, fsq_pkg::REG_CTRL, 32'h0000_0009);
    wt(3, 1'b0, 40);
    wt(3, 1'b1, 500);
    ck("io3_off", 32'h0, hw_busy);
    @(posedge clock);
    por_fault <= 1'b1;
    sys_rst <= 1'b1;
    repeat (5) @(posedge clock);
    sys_rst <= 1'b0;
    wt(1, 1'b1, PU + 40);
    pulse_b(fsq_pkg::RESET_PULSE_CYC);
    wt(6, 1'b1, 30);
    wt(1, 1'b1, PU + 60);
    ck("por_len", 32'h1, 32'(n >= PU - 4 && n <= PU + 4));
    conclude();
  end
endmodule : test_flash_reset_sequencer
